// [sebs_ctl_model.sv]
// two-wire bus controller model facing the eeprom target
`timescale 1ns/100ps
`default_nettype none

module sebs_ctl_model #(
  parameter int Q = 8
) (
  input  wire logic CLK_SYS,
  input  wire logic SDA_OE,
  output var  logic SCL,
  output wire logic SDA_I
);
  logic sda_low = 1'b0;

  // wired-and with pull-up, a released line reads high
  assign SDA_I = !(sda_low || SDA_OE);
  initial SCL = 1'b1;

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask
  // one bit: data set mid-low, sampled mid-high
  task automatic bitx(input logic b, output logic s);
    cyc(Q);
    sda_low <= !b;
    cyc(Q);
    SCL <= 1'b1;
    cyc(Q);
    s = SDA_I;
    cyc(Q);
    SCL <= 1'b0;
  endtask
  // from a low clock this is a repeated start
  task automatic start();
    cyc(Q);
    sda_low <= 1'b0;
    cyc(Q);
    SCL <= 1'b1;
    cyc(Q);
    sda_low <= 1'b1;
    cyc(Q);
    SCL <= 1'b0;
  endtask
  task automatic stop();
    cyc(Q);
    sda_low <= 1'b1;
    cyc(Q);
    SCL <= 1'b1;
    cyc(Q);
    sda_low <= 1'b0;
    cyc(2 * Q);
  endtask
  // byte out msb first, then the target's acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], s);
    bitx(1'b1, s);
    ack = !s;
  endtask
  // byte in; no acknowledge ends the read
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, s);
      d[i] = s;
    end
    bitx(!ack, s);
  endtask
endmodule
`default_nettype wire

// [sebs_pin_filter.sv]
// two-stage synchroniser and spike filter for one input pin
`timescale 1ns/100ps
`default_nettype none

module sebs_pin_filter
  import sebs_pkg::*;
#(
  parameter logic RST_LVL = 1'b1
) (
  input  wire logic CLK_SYS,
  input  wire logic RSTN,
  input  wire logic CE,
  input  wire logic PIN,
  output logic      LEVEL
);

  sebs_filt_s r;
  sebs_filt_s n;

  // level changes only after it stood for more than the spike width
  always_comb begin
    n = r;
    if (CE) begin
      n.s1 = PIN;
      n.s2 = r.s1;
      if (r.s2 == r.lvl) begin
        n.cnt = '0;
      end else if (r.cnt == FILT_CNT_W'(SPIKE_CYC)) begin
        n.lvl = r.s2;
        n.cnt = '0;
      end else begin
        n.cnt = r.cnt + 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      r <= '{s1: RST_LVL, s2: RST_LVL, lvl: RST_LVL, cnt: '0};
    end else begin
      r <= n;
    end
  end

  assign LEVEL = r.lvl;

endmodule

`default_nettype wire

// [sebs_pkg.sv]
// constants, types and timing counts of the serial eeprom bus target
package sebs_pkg;

  // clock and timing figures
  localparam int CLK_PERIOD_NS = 100;
  localparam int SPIKE_NS      = 50;
  localparam int SPIKE_RAW     = SPIKE_NS / CLK_PERIOD_NS;
  localparam int SPIKE_CYC     = (SPIKE_RAW < 1) ? 1 : SPIKE_RAW;
  localparam int HOLD_NS       = 300;
  localparam int HOLD_CYC      = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TWR_TYP_MS    = 2;
  localparam int TWR_MAX_MS    = 10;
  localparam int NS_PER_MS     = 1000000;
  localparam int TWR_CYC       = TWR_TYP_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int TWR_MAX_CYC   = TWR_MAX_MS * (NS_PER_MS / CLK_PERIOD_NS);

  // counter widths
  localparam int FILT_CNT_W = 3;
  localparam int HOLD_CNT_W = 3;
  localparam int WR_CNT_W   = 17;

  // pin indices of the input filters
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_WP  = 2;
  localparam int PIN_N   = 3;

  // control byte and memory layout
  localparam logic [3:0] CTRL_CODE  = 4'ha;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [2:0] BLOCK_MASK = 3'h3;
  localparam int ADDR_W     = 11;
  localparam int MEM_IDX_W  = 10;
  localparam int MEM_BYTES  = 1024;
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_IDX_W = 4;
  localparam int PAGE_HI_W  = MEM_IDX_W - PAGE_IDX_W;

  // protocol states and byte roles
  typedef enum logic [2:0] {
    S_IDLE, S_RX, S_RX_ACK, S_TX, S_TX_ACK, S_WAIT
  } sebs_state_e;

  typedef enum logic [1:0] {
    ROLE_CTRL, ROLE_ADDR, ROLE_DATA
  } sebs_role_e;

  // state of one input filter
  typedef struct packed {
    logic                  s1;
    logic                  s2;
    logic                  lvl;
    logic [FILT_CNT_W-1:0] cnt;
  } sebs_filt_s;

  // state of the bus target
  typedef struct packed {
    sebs_state_e                   state;
    sebs_role_e                    role;
    logic                          is_read;
    logic [3:0]                    bit_cnt;
    logic [7:0]                    shift;
    logic [2:0]                    ctrl_blk;
    logic [ADDR_W-1:0]             ptr;
    logic                          scl_q;
    logic                          sda_q;
    logic                          fall_pend;
    logic [HOLD_CNT_W-1:0]         hold_cnt;
    logic [PAGE_BYTES-1:0][7:0]    page_buf;
    logic [PAGE_BYTES-1:0]         page_vld;
    logic [PAGE_HI_W-1:0]          page_base;
    logic                          busy;
    logic [WR_CNT_W-1:0]           wr_cnt;
    logic                          commit;
    logic                          sda_oe;
    logic                          sda_lvl;
    logic                          bus_idle;
  } sebs_top_s;

endpackage

// [sebs_top.sv]
// two-wire serial eeprom bus target with page buffer and write cycle
`timescale 1ns/100ps
`default_nettype none

module sebs_top
  import sebs_pkg::*;
#(
  parameter int TWR_CYC_P = TWR_CYC
) (
  input  wire logic CLK_SYS,
  input  wire logic RSTN,
  input  wire logic CE,
  input  wire logic SCL,
  input  wire logic SDA_I,
  input  wire logic WP,
  output logic      SDA_O,
  output logic      SDA_OE,
  output logic      BUS_IDLE,
  output logic      WRITE_BUSY
);

  localparam sebs_top_s TOP_RST = '{
    state:    S_IDLE,
    role:     ROLE_CTRL,
    scl_q:    1'b1,
    sda_q:    1'b1,
    bus_idle: 1'b1,
    default:  '0
  };

  sebs_top_s          r;
  sebs_top_s          n;
  logic [PIN_N-1:0]   pin_raw;
  logic [PIN_N-1:0]   pin_flt;
  logic [7:0]         mem [MEM_BYTES];
  logic [7:0]         mem_rd;
  logic               scl;
  logic               sda;
  logic               wp;
  logic               scl_rise;
  logic               scl_fall;
  logic               start_det;
  logic               stop_det;
  logic               fall_act;

  // pins in the order of the filter indices
  assign pin_raw[PIN_SCL] = SCL;
  assign pin_raw[PIN_SDA] = SDA_I;
  assign pin_raw[PIN_WP]  = WP;

  // one synchroniser and spike filter per input pin
  genvar g;
  generate
    for (g = 0; g < PIN_N; g++) begin : g_pin
      sebs_pin_filter #(
        .RST_LVL (1'b1)
      ) u_filt (
        .CLK_SYS (CLK_SYS),
        .RSTN    (RSTN),
        .CE      (CE),
        .PIN     (pin_raw[g]),
        .LEVEL   (pin_flt[g])
      );
    end
  endgenerate

  // filtered levels and edge events
  assign scl       = pin_flt[PIN_SCL];
  assign sda       = pin_flt[PIN_SDA];
  assign wp        = pin_flt[PIN_WP];
  assign scl_rise  = scl & ~r.scl_q;
  assign scl_fall  = ~scl & r.scl_q;
  assign start_det = r.scl_q & scl & r.sda_q & ~sda;
  assign stop_det  = r.scl_q & scl & ~r.sda_q & sda;
  assign fall_act  = r.fall_pend && (r.hold_cnt == '0);
  assign mem_rd    = mem[r.ptr[MEM_IDX_W-1:0]];

  // protocol engine, write timer and output hold-off
  always_comb begin
    n = r;
    if (CE) begin
      n.scl_q    = scl;
      n.sda_q    = sda;
      n.bus_idle = scl & sda;
      n.commit   = 1'b0;

      // buffer is emptied once it has been programmed
      if (r.commit) begin
        n.page_vld = '0;
      end

      // self-timed write cycle
      if (r.busy) begin
        if (r.wr_cnt == '0) begin
          n.busy   = 1'b0;
          n.commit = 1'b1;
        end else begin
          n.wr_cnt = r.wr_cnt - 1'b1;
        end
      end

      // every clock fall arms the hold-off before acting
      if (scl_fall) begin
        n.fall_pend = 1'b1;
        n.hold_cnt  = HOLD_CNT_W'(HOLD_CYC - 1);
      end else if (r.fall_pend) begin
        if (r.hold_cnt == '0) begin
          n.fall_pend = 1'b0;
        end else begin
          n.hold_cnt = r.hold_cnt - 1'b1;
        end
      end

      if (start_det) begin
        // conditions outrank any data bit
        n.state     = S_RX;
        n.role      = ROLE_CTRL;
        n.bit_cnt   = '0;
        n.sda_oe    = 1'b0;
        n.fall_pend = 1'b0;
        if (!r.busy && !r.commit) begin
          n.page_vld = '0;
        end
      end else if (stop_det) begin
        n.state     = S_IDLE;
        n.sda_oe    = 1'b0;
        n.fall_pend = 1'b0;
        if (|r.page_vld && !r.busy && !r.commit) begin
          if (wp) begin
            n.page_vld = '0;
          end else begin
            n.busy   = 1'b1;
            n.wr_cnt = WR_CNT_W'(TWR_CYC_P - 1);
          end
        end
      end else begin
        case (r.state)
          S_RX: begin
            if (scl_rise && r.bit_cnt != BYTE_BITS) begin
              n.shift   = {r.shift[6:0], sda};
              n.bit_cnt = r.bit_cnt + 1'b1;
            end else if (fall_act && r.bit_cnt == BYTE_BITS) begin
              n.state  = S_RX_ACK;
              n.sda_oe = 1'b1;
              case (r.role)
                ROLE_CTRL: begin
                  if (r.shift[7:4] != CTRL_CODE || r.busy) begin
                    n.state  = S_WAIT;
                    n.sda_oe = 1'b0;
                  end else begin
                    n.is_read  = r.shift[0];
                    n.ctrl_blk = r.shift[3:1] & BLOCK_MASK;
                    if (r.shift[0]) begin
                      n.ptr = {r.shift[3:1] & BLOCK_MASK, r.ptr[7:0]};
                    end
                  end
                end
                ROLE_ADDR: begin
                  n.ptr = {r.ctrl_blk, r.shift};
                end
                ROLE_DATA: begin
                  n.page_buf[r.ptr[PAGE_IDX_W-1:0]] = r.shift;
                  n.page_vld[r.ptr[PAGE_IDX_W-1:0]] = 1'b1;
                  n.page_base = r.ptr[MEM_IDX_W-1:PAGE_IDX_W];
                  n.ptr[PAGE_IDX_W-1:0] =
                    r.ptr[PAGE_IDX_W-1:0] + 1'b1;
                end
                default: begin
                  n.state  = S_WAIT;
                  n.sda_oe = 1'b0;
                end
              endcase
            end
          end
          S_RX_ACK: begin
            // acknowledge stays low until the ninth fall is passed
            if (fall_act) begin
              n.bit_cnt = '0;
              if (r.role == ROLE_CTRL && r.is_read) begin
                n.state  = S_TX;
                n.role   = ROLE_DATA;
                n.shift  = mem_rd;
                n.sda_oe = ~mem_rd[7];
                n.ptr    = r.ptr + 1'b1;
              end else begin
                n.sda_oe = 1'b0;
                n.state  = S_RX;
                n.role   = (r.role == ROLE_CTRL) ? ROLE_ADDR : ROLE_DATA;
              end
            end
          end
          S_TX: begin
            if (scl_rise) begin
              n.bit_cnt = r.bit_cnt + 1'b1;
              n.shift   = {r.shift[6:0], 1'b0};
            end else if (fall_act) begin
              if (r.bit_cnt == BYTE_BITS) begin
                n.sda_oe = 1'b0;
                n.state  = S_TX_ACK;
              end else begin
                n.sda_oe = ~r.shift[7];
              end
            end
          end
          S_TX_ACK: begin
            if (scl_rise) begin
              if (sda) begin
                n.state = S_WAIT;
              end else begin
                n.bit_cnt = '0;
              end
            end else if (fall_act && r.bit_cnt == '0) begin
              n.state  = S_TX;
              n.shift  = mem_rd;
              n.sda_oe = ~mem_rd[7];
              n.ptr    = r.ptr + 1'b1;
            end
          end
          S_IDLE, S_WAIT: begin
            n.sda_oe = 1'b0;
          end
          default: begin
            n.state  = S_IDLE;
            n.sda_oe = 1'b0;
          end
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      r <= TOP_RST;
    end else begin
      r <= n;
    end
  end

  // array programming at the end of the write cycle
  always_ff @(posedge CLK_SYS) begin
    if (CE && r.commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (r.page_vld[i]) begin
          mem[{r.page_base, PAGE_IDX_W'(i)}] <= r.page_buf[i];
        end
      end
    end
  end

  // outputs straight from the state register
  assign SDA_O      = r.sda_lvl;
  assign SDA_OE     = r.sda_oe;
  assign BUS_IDLE   = r.bus_idle;
  assign WRITE_BUSY = r.busy;

endmodule

`default_nettype wire

// [sebs_top_chk.sv]
// port checker for the eeprom bus target, bound into its top
`timescale 1ns/100ps
`default_nettype none

module sebs_top_chk
  import sebs_pkg::*;
#(
  parameter int TWR_CYC_P = TWR_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic SCL,
  input wire logic SDA_I,
  input wire logic WP,
  input wire logic SDA_O,
  input wire logic SDA_OE,
  input wire logic BUS_IDLE,
  input wire logic WRITE_BUSY
);
  int         bcnt;
  logic [3:0] lcnt;

  // busy length and cycles since the clock pin went low
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      bcnt <= 0;
      lcnt <= 4'h0;
    end else begin
      bcnt <= WRITE_BUSY ? bcnt + (CE ? 1 : 0) : 0;
      lcnt <= SCL ? 4'h0 : lcnt + {3'h0, lcnt != 4'hf};
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);

  AST_DRV_ZERO: assert property (SDA_O == 1'b0)
    else $error("data drive value not zero");
  AST_IDLE: assert property ((SCL && SDA_I)[*8] |=> BUS_IDLE)
    else $error("idle not flagged with both lines high");
  AST_HOLDOFF: assert property ($rose(SDA_OE) |-> lcnt >= 4'h3)
    else $error("data pulled too soon after clock fall");
  AST_NO_ACK_BUSY: assert property (WRITE_BUSY && $past(WRITE_BUSY)
    |-> !$rose(SDA_OE))
    else $error("line pulled during write cycle");
  AST_BUSY_LEN: assert property ($fell(WRITE_BUSY) |->
    bcnt >= TWR_CYC_P && bcnt <= TWR_CYC_P + 1)
    else $error("write cycle length wrong");
  AST_BUSY_START: assert property ($rose(WRITE_BUSY) |-> SCL && SDA_I)
    else $error("write cycle began without stop");
  AST_WP_BLOCK: assert property ($rose(WRITE_BUSY) |->
    !WP && !$past(WP, 8))
    else $error("write cycle while protected");
  AST_ACK_HOLD: assert property ($rose(SDA_OE) |=> SDA_OE[*8])
    else $error("pulled low too briefly");
endmodule

bind sebs_top sebs_top_chk #(.TWR_CYC_P(TWR_CYC_P)) sebs_top_chk_inst (
  .CLK_SYS(CLK_SYS), .RSTN(RSTN), .CE(CE), .SCL(SCL), .SDA_I(SDA_I),
  .WP(WP), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .BUS_IDLE(BUS_IDLE),
  .WRITE_BUSY(WRITE_BUSY)
);
`default_nettype wire

// [serial_eeprom_bus_slave_tb_top.sv]
// self-checking bench for the eeprom bus target
`timescale 1ns/100ps
`default_nettype none

module serial_eeprom_bus_slave_tb_top
  import sebs_pkg::*;
;
  localparam int TWR = 400;
  logic        CLK_SYS = 1'b0;
  logic        RSTN    = 1'b0;
  logic        CE      = 1'b1;
  logic        WP      = 1'b0;
  wire logic   SCL, SDA_I, SDA_O, SDA_OE, BUS_IDLE, WRITE_BUSY;
  logic [7:0]  mem [MEM_BYTES];
  logic [31:0] rnd = 32'heb3b1661;
  int          failures = 0;
  int          tests_run = 0;
  logic        ack;
  logic [1:0]  blk;
  logic [7:0]  wd;

  initial forever #50 CLK_SYS = !CLK_SYS;

  sebs_top #(.TWR_CYC_P(TWR)) sebs_top_inst (.CLK_SYS, .RSTN, .CE,
    .SCL, .SDA_I, .WP, .SDA_O, .SDA_OE, .BUS_IDLE, .WRITE_BUSY);
  // slowed link so the 300 ns hold-off fits each 800 ns phase
  sebs_ctl_model #(.Q(8)) sebs_ctl_model_inst (.CLK_SYS, .SDA_OE,
    .SCL, .SDA_I);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk1(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic chk8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // page write of n random bytes; keep low when protected
  task automatic wr(input logic [1:0] b, input logic [7:0] w, input int n,
                    input logic keep);
    logic       a;
    logic [7:0] v;
    sebs_ctl_model_inst.start();
    sebs_ctl_model_inst.wbyte({4'ha, rnd[8], b, 1'b0}, a);
    chk1("ctrl ack", 1'b1, a);
    sebs_ctl_model_inst.wbyte(w, a);
    chk1("addr ack", 1'b1, a);
    for (int i = 0; i < n; i++) begin
      rnd = lfsr(rnd);
      v = rnd[7:0];
      sebs_ctl_model_inst.wbyte(v, a);
      chk1("data ack", 1'b1, a);
      if (keep)
        mem[{b, w[7:4], w[3:0] + i[3:0]}] = v;
    end
    sebs_ctl_model_inst.stop();
  endtask
  // random read then sequential read, last byte refused
  task automatic rd(input logic [1:0] b, input logic [7:0] w, input int n);
    logic       a;
    logic [7:0] v;
    sebs_ctl_model_inst.start();
    sebs_ctl_model_inst.wbyte({4'ha, 1'b0, b, 1'b0}, a);
    chk1("ready ack", 1'b1, a);
    sebs_ctl_model_inst.wbyte(w, a);
    sebs_ctl_model_inst.start();
    sebs_ctl_model_inst.wbyte({4'ha, 1'b0, b, 1'b1}, a);
    chk1("read ack", 1'b1, a);
    for (int i = 0; i < n; i++) begin
      sebs_ctl_model_inst.rbyte(i < n - 1, v);
      chk8("read data", mem[{b, w + i[7:0]}], v);
    end
    sebs_ctl_model_inst.cyc(10);
    chk1("released", 1'b0, SDA_OE);
    sebs_ctl_model_inst.stop();
  endtask

  // watchdog, about two and a half times the expected run
  initial begin
    #5000000;
    failures++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    sebs_ctl_model_inst.cyc(2);
    chk1("oe", 1'b0, SDA_OE);
    chk1("idle", 1'b1, BUS_IDLE);
    chk1("busy", 1'b0, WRITE_BUSY);
    sebs_ctl_model_inst.cyc(8);
    sebs_ctl_model_inst.start();
    sebs_ctl_model_inst.cyc(10);
    chk1("idle", 1'b0, BUS_IDLE);
    sebs_ctl_model_inst.wbyte(8'hb0, ack);
    chk1("bad code ack", 1'b0, ack);
    sebs_ctl_model_inst.stop();
    chk1("idle", 1'b1, BUS_IDLE);
    $display("test reset and code done");
    rnd = lfsr(rnd);
    blk = rnd[1:0];
    wd = {rnd[7:4], 4'he};
    wr(blk, wd, 18, 1'b1);
    sebs_ctl_model_inst.cyc(2);
    chk1("busy", 1'b1, WRITE_BUSY);
    sebs_ctl_model_inst.start();
    sebs_ctl_model_inst.wbyte({4'ha, 1'b0, blk, 1'b0}, ack);
    chk1("poll ack", 1'b0, ack);
    sebs_ctl_model_inst.stop();
    // clock enable low freezes the write timer
    CE <= 1'b0;
    sebs_ctl_model_inst.cyc(TWR + 50);
    chk1("frozen busy", 1'b1, WRITE_BUSY);
    CE <= 1'b1;
    for (int i = 0; i < 1000 && WRITE_BUSY !== 1'b0; i++)
      sebs_ctl_model_inst.cyc(1);
    rd(blk, {wd[7:4], 4'h0}, 16);
    $display("test page write done");
    WP <= 1'b1;
    sebs_ctl_model_inst.cyc(8);
    wr(blk, wd, 3, 1'b0);
    sebs_ctl_model_inst.cyc(4);
    chk1("busy", 1'b0, WRITE_BUSY);
    WP <= 1'b0;
    rd(blk, {wd[7:4], 4'h0}, 16);
    $display("test protect done");
    give_verdict();
  end
endmodule
`default_nettype wire
